// file: logic/oidsr_pkg.sv
package oidsr_pkg;

    // clock rate in kHz keeps every product below 2**31
    localparam int CLK_KHZ = 200000;

    // debounce times in nanoseconds, as selected by the two select inputs
    localparam int DEB_TIME1_NS = 25000;
    localparam int DEB_TIME2_NS = 750000;
    localparam int DEB_TIME3_NS = 3000000;

    // one filter period is a third of the debounce time; counts round down
    localparam int TICK1_CYC = DEB_TIME1_NS / 3 * (CLK_KHZ / 1000) / 1000;
    localparam int TICK2_CYC = DEB_TIME2_NS / 3 * (CLK_KHZ / 1000) / 1000;
    localparam int TICK3_CYC = DEB_TIME3_NS / 3 * (CLK_KHZ / 1000) / 1000;
    localparam int TICK_W    = 18;

    // filter accepts after this many stable periods
    localparam int STABLE_PERIODS = 3;

    localparam int NUM_INPUTS  = 8;
    localparam int CRC_W       = 5;
    localparam int FRAME_LONG  = 16;
    localparam int FRAME_SHORT = 8;
    localparam int CNT_W       = 5;

    // x^5 + x^4 + x^2 + 1, low five coefficients
    localparam logic [4:0] CRC_POLY = 5'h15;
    localparam logic [4:0] CRC_INIT = 5'h1f;

    // filter-period lengths indexed by debounce select value
    localparam logic [TICK_W-1:0] TICK_SEL [4] = '{
        TICK_W'(1), TICK_W'(TICK1_CYC), TICK_W'(TICK2_CYC),
        TICK_W'(TICK3_CYC)};

    typedef struct packed {
        logic supplyLowFlag;
        logic overtempFlag;
        logic supplyWarningFlag;
    } oidsr_status_type;

    typedef struct packed {
        logic csN;
        logic sclk;
    } oidsr_link_type;

endpackage

// file: logic/oidsr_debounce.sv
`timescale 1ns/1ps

module oidsr_debounce
(
    // clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  srst,
    // control
    input  wire logic [1:0]                            debounceSelect,
    input  wire logic                                  periodTick,
    // data
    input  wire logic [oidsr_pkg::NUM_INPUTS-1:0]      rawInputs,
    output logic      [oidsr_pkg::NUM_INPUTS-1:0]      filtered
);

    genvar gi;
    generate
        for (gi = 0; gi < oidsr_pkg::NUM_INPUTS; gi++)
        begin : gChan
            logic       candidate_r;
            logic [1:0] stable_r;

            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    candidate_r <= 1'b0;
                    stable_r    <= 2'h0;
                    filtered[gi] <= 1'b0;
                end
                else if (debounceSelect == 2'h0)
                begin
                    // no filtering: straight through
                    candidate_r  <= rawInputs[gi];
                    stable_r     <= 2'h0;
                    filtered[gi] <= rawInputs[gi]; // R20
                end
                else if (periodTick)
                begin
                    if (rawInputs[gi] != candidate_r)
                    begin
                        // unstable change dropped, restart count
                        candidate_r <= rawInputs[gi]; // R4
                        stable_r    <= 2'h0;
                    end
                    else if (stable_r ==
                             2'(oidsr_pkg::STABLE_PERIODS - 1))
                        filtered[gi] <= candidate_r; // R3
                    else
                        stable_r <= stable_r + 2'h1;
                end
            end
        end
    endgenerate

endmodule // oidsr_debounce

// file: logic/oidsr_top.sv
// What this block does
// R1 - two select inputs pick debounce: none, 25us, 0.75ms or 3ms
// R2 - one shared debounce time applies to all eight inputs
// R3 - new level accepted after three stable periods of a third each
// R4 - changes not stable for three periods are discarded
// R5 - chip select falling captures filtered inputs and enables link
// R6 - frame select high: send only the eight input bits
// R7 - frame select low: send inputs, five-bit check code, three flags
// R8 - order: input 8 to 1, check bits, low, overtemp, warning
// R9 - mode 0 link: clock idles low, controller samples on rise
// R10 - first bit appears on chip select assertion, no clock needed
// R11 - later bits advance on falling clock edges, MSB first
// R12 - serial output held high while chip select is high
// R13 - controller ignores bits after input 1 in short frames
// R14 - chained parts share select and clock, outputs feed upstream
// R15 - check code polynomial x^5 + x^4 + x^2 + 1
// R16 - low-supply flag is 0 when low and raises fault
// R17 - overtemp flag is 1 when hot and raises fault
// R18 - warning flag only in frame, never raises fault
// R19 - check code covers eleven latched bits of the same frame
// R20 - select zero passes synchronised inputs unfiltered
`timescale 1ns/1ps

module oidsr_top
(
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              srst,
    // field side
    input  wire logic [oidsr_pkg::NUM_INPUTS-1:0]  fieldInputs,
    input  wire logic                              debounce_select_low_bit,
    input  wire logic                              debounce_select_high_bit,
    input  wire logic                              frame_length_select,
    input  wire logic                              chain_serial_in,
    // monitors, active when the condition holds
    input  wire logic                              supplyLowAlarm,
    input  wire logic                              supplyWarnAlarm,
    input  wire logic                              overtempAlarm,
    // serial link
    input  wire logic                              chipSelectN,
    input  wire logic                              serialClock,
    output logic                                   serialOut,
    // status
    output logic                                   fault
);

    localparam int NI = oidsr_pkg::NUM_INPUTS;

    // two-stage synchronisers for everything from outside
    logic [NI+8:0] sync1_r;
    logic [NI+8:0] sync2_r;

    // select rests high in reset, else a false select edge follows release
    localparam logic [NI+8:0] SYNC_IDLE = {{(NI+6){1'b0}}, 3'h4};

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
        end
        else
        begin
            sync1_r <= {fieldInputs, debounce_select_high_bit,
                        debounce_select_low_bit, frame_length_select,
                        supplyLowAlarm, supplyWarnAlarm, overtempAlarm,
                        chipSelectN, serialClock, chain_serial_in};
            sync2_r <= sync1_r;
        end
    end

    logic [NI-1:0]              inSync;
    logic [1:0]                 debSel;
    logic                       shortFrame;
    oidsr_pkg::oidsr_status_type alarmSync;
    oidsr_pkg::oidsr_link_type   link;

    assign inSync     = sync2_r[NI+8:9];
    // binary value: low-bit pin is the high bit of the select code
    assign debSel     = {sync2_r[7], sync2_r[8]}; // R1
    assign shortFrame = sync2_r[6];
    assign link       = '{csN: sync2_r[2], sclk: sync2_r[1]};

    // supply flags read 0 while their condition holds, overtemp reads 1
    always_comb
    begin
        alarmSync.supplyLowFlag     = ~sync2_r[5]; // R16
        alarmSync.overtempFlag      = sync2_r[3]; // R17
        alarmSync.supplyWarningFlag = ~sync2_r[4]; // R18
    end

    // shared filter-period timer for all channels
    logic [oidsr_pkg::TICK_W-1:0] tickCnt_r;
    logic                         periodTick;

    // restart the period timer on a new selection so it takes effect at once
    logic [1:0] debSelPrev_r;

    always_ff @(posedge clock)
    begin
        if (srst)
            debSelPrev_r <= 2'h0;
        else
            debSelPrev_r <= debSel;
    end

    assign periodTick = (tickCnt_r == '0);

    always_ff @(posedge clock)
    begin
        if (srst)
            tickCnt_r <= '0;
        else if (periodTick || (debSel != debSelPrev_r))
            tickCnt_r <= oidsr_pkg::TICK_SEL[debSel] -
                         oidsr_pkg::TICK_W'(1); // R1 R2
        else
            tickCnt_r <= tickCnt_r - oidsr_pkg::TICK_W'(1);
    end

    logic [NI-1:0] filtered;

    oidsr_debounce uFilter
    (
        .clock          (clock),
        .srst           (srst),
        .debounceSelect (debSel),
        .periodTick     (periodTick),
        .rawInputs      (inSync),
        .filtered       (filtered)
    );

    // crc over 11 bits, msb first
    function automatic logic [4:0] crcCalc(input logic [10:0] data);
        logic [4:0] crc;
        logic       fb;
        crc = oidsr_pkg::CRC_INIT;
        for (int i = 10; i >= 0; i--)
        begin
            fb  = crc[4] ^ data[i];
            crc = {crc[3:0], 1'b0} ^ (fb ? oidsr_pkg::CRC_POLY : 5'h00);
        end
        return crc;
    endfunction

    // link edge detection on synchronised copies
    logic csPrev_r;
    logic sclkPrev_r;
    logic csFall;
    logic sclkFall;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            csPrev_r   <= 1'b1;
            sclkPrev_r <= 1'b0;
        end
        else
        begin
            csPrev_r   <= link.csN;
            sclkPrev_r <= link.sclk;
        end
    end

    // falling edge between the last two synchronised samples
    function automatic logic fellNow(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    assign csFall   = fellNow(csPrev_r, link.csN);
    // mode 0: clock idles low, data moves on falling edges
    assign sclkFall = fellNow(sclkPrev_r, link.sclk) & ~link.csN; // R9

    // frame shift register
    logic [oidsr_pkg::FRAME_LONG-1:0] shift_r;
    logic [oidsr_pkg::FRAME_LONG-1:0] frameNxt;
    logic [10:0]                      crcData;

    always_comb
    begin
        // inputs 8..1 then flags low, overtemp, warning
        crcData  = {filtered, alarmSync.supplyLowFlag,
                    alarmSync.overtempFlag,
                    alarmSync.supplyWarningFlag}; // R19
        frameNxt = {filtered, crcCalc(crcData),
                    alarmSync.supplyLowFlag, alarmSync.overtempFlag,
                    alarmSync.supplyWarningFlag}; // R7 R8 R15 R16 R17 R18
        if (shortFrame)
            frameNxt = {filtered, 8'hff}; // R6
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            shift_r <= '1;
        else if (csFall)
            shift_r <= frameNxt; // R5
        else if (sclkFall)
            // chain data fills from below for daisy chaining
            shift_r <= {shift_r[oidsr_pkg::FRAME_LONG-2:0],
                        sync2_r[0]}; // R11
    end

    // output register: msb as soon as select falls, high when idle
    always_ff @(posedge clock)
    begin
        if (srst)
            serialOut <= 1'b1;
        else if (link.csN)
            serialOut <= 1'b1; // R12
        else if (csFall)
            serialOut <= frameNxt[oidsr_pkg::FRAME_LONG-1]; // R10
        else if (sclkFall)
            serialOut <= shift_r[oidsr_pkg::FRAME_LONG-2]; // R11
    end

    logic faultNxt;

    // warning never feeds the fault pin
    assign faultNxt = ~alarmSync.supplyLowFlag | alarmSync.overtempFlag;

    always_ff @(posedge clock)
    begin
        if (srst)
            fault <= 1'b0;
        else
            fault <= faultNxt; // R16 R17 R18
    end

endmodule // oidsr_top

// file: testbench/oidsr_assertions.sv
`timescale 1ns/1ps

module oidsr_assertions
(
    // clock and reset
    input logic clock,
    input logic srst,
    // watched pins
    input logic chipSelectN,
    input logic serialClock,
    input logic serialOut,
    input logic supplyLowAlarm,
    input logic overtempAlarm,
    input logic fault
);
    logic [3:0] quiet_r;
    wire        hot = supplyLowAlarm | overtempAlarm;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // sync plus edge detect leaves a few cycles of slack after each edge
    always_ff @(posedge clock)
        if (srst || $changed(chipSelectN) || $fell(serialClock))
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;

    a_out_quiet: assert property (quiet_r > 4'h7 |-> $stable(serialOut))
        else $error("serial output moved without a link edge");
    a_idle_high: assert property (chipSelectN [*6] |-> serialOut)
        else $error("serial output low while deselected");
    a_cs_release: assert property
        ($rose(chipSelectN) |-> ##[1:6] serialOut)
        else $error("serial output not high after deselect");
    a_cs_hold: assert property
        ($fell(chipSelectN) |=> $stable(serialOut) [*2])
        else $error("serial output moved before select was seen");
    a_bit_hold: assert property
        (!chipSelectN && $fell(serialClock) |=> $stable(serialOut) [*2])
        else $error("serial output moved before clock fall was seen");
    a_fault_on: assert property (hot [*5] |-> fault)
        else $error("fault missing during alarm");
    a_fault_off: assert property (!hot [*5] |-> !fault)
        else $error("fault without low supply or overtemp");
    a_fault_cause: assert property ($rose(fault) |->
        $past(hot) || $past(hot, 2) || $past(hot, 3) || $past(hot, 4))
        else $error("fault rose without a cause");

    c_select: cover property ($fell(chipSelectN));
    c_fault: cover property ($rose(fault));
    c_shift: cover property (!chipSelectN && $fell(serialClock));
endmodule // oidsr_assertions

bind oidsr_top oidsr_assertions i_chk
(
    .clock(clock), .srst(srst), .chipSelectN(chipSelectN),
    .serialClock(serialClock), .serialOut(serialOut),
    .supplyLowAlarm(supplyLowAlarm), .overtempAlarm(overtempAlarm),
    .fault(fault)
);

// file: testbench/oidsr_host.sv
`timescale 1ns/1ps

module oidsr_host
(
    // system side
    input  logic        clock,
    output logic [15:0] rxWord,
    output logic        rxValid,
    // serial link
    output logic        chipSelectN,
    output logic        serialClock,
    input  logic        serialOut
);
    initial
    begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
        rxWord = 16'h0000;
        rxValid = 1'b0;
    end

    // low phase longer than high: a new bit settles ~11 to 15 ns after a fall
    task automatic transfer(input int n);
        logic [15:0] w;
        w = 16'h0000;
        @(posedge clock);
        // fractional offset keeps link edges off the sampling clock edges
        #1.2 chipSelectN = 1'b0;
        repeat (n)
        begin
            #28 serialClock = 1'b1;
            w = {w[14:0], serialOut};
            #20 serialClock = 1'b0;
        end
        #28 chipSelectN = 1'b1;
        @(posedge clock);
        rxWord <= w;
        rxValid <= 1'b1;
        @(posedge clock);
        rxValid <= 1'b0;
    endtask
endmodule // oidsr_host

// file: testbench/oidsr_top_test.sv
`timescale 1ns/1ps

module oidsr_top_test;
    logic        clock, srst, frameSel, chainIn, lowA, warnA, hotA;
    logic [1:0]  dbSel;
    logic [7:0]  fieldIn, shown;
    logic        csN, sclk, sout, fault, rxValid;
    logic [15:0] rxWord;
    logic [15:0] expQ [$];
    int          nMismatch, totalChecks;

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    oidsr_top i_dut
    (
        .clock(clock), .srst(srst), .fieldInputs(fieldIn),
        .debounce_select_low_bit(dbSel[1]),
        .debounce_select_high_bit(dbSel[0]),
        .frame_length_select(frameSel), .chain_serial_in(chainIn),
        .supplyLowAlarm(lowA), .supplyWarnAlarm(warnA),
        .overtempAlarm(hotA), .chipSelectN(csN), .serialClock(sclk),
        .serialOut(sout), .fault(fault)
    );

    oidsr_host i_host
    (
        .clock(clock), .rxWord(rxWord), .rxValid(rxValid),
        .chipSelectN(csN), .serialClock(sclk), .serialOut(sout)
    );

    function automatic logic [15:0] exp16(logic [7:0] d, logic l, o, w);
        logic [10:0] b;
        logic [4:0]  c;
        logic        fb;
        b = {d, l, o, w};
        c = 5'h1f;
        for (int i = 10; i >= 0; i--)
        begin
            fb = c[4] ^ b[i];
            c = {c[3:0], 1'b0};
            if (fb)
                c = c ^ 5'h15;
        end
        return {d, c, l, o, w};
    endfunction

    task automatic check(input logic [15:0] seen, exp);
        totalChecks++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic frame(input int n);
        logic [15:0] e;
        e = exp16(shown, ~lowA, hotA, ~warnA);
        if (n == 8)
            e = {8'h00, shown};
        else if (n > 16)
            e = {e[7:0], {8{chainIn}}};
        expQ.push_back(e);
        i_host.transfer(n);
        repeat (8) @(posedge clock);
        check({15'h0, sout}, 16'h0001);
    endtask

    task automatic setIn(input logic [7:0] d, input int n);
        @(posedge clock);
        fieldIn <= d;
        repeat (n) @(posedge clock);
    endtask

    task automatic conclude;
        $display("mismatches %0d checks %0d", nMismatch, totalChecks);
        if (nMismatch == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clock)
        if (rxValid)
            check(rxWord, expQ.pop_front());

    initial
    begin
        #400000;
        nMismatch++;
        conclude;
    end

    initial
    begin
        srst = 1'b1;
        {dbSel, frameSel, chainIn, lowA, warnA, hotA} = 7'h00;
        fieldIn = 8'h00;
        shown = 8'h00;
        void'($urandom(32'h10c7));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            fieldIn <= 8'($urandom);
            frameSel <= i[0];
            chainIn <= 1'($urandom);
            {lowA, warnA, hotA} <= 3'($urandom);
            repeat (8) @(posedge clock);
            shown = fieldIn;
            check({15'h0, fault}, {15'h0, lowA | hotA});
            frame(frameSel ? 8 : 16);
        end
        dbSel <= 2'h1;
        frameSel <= 1'b0;
        setIn(~shown, 1000);
        setIn(shown, 8000);
        frame(16);
        frame(24);
        setIn(~shown, 7000);
        shown = ~shown;
        frame(16);
        dbSel <= 2'h2;
        setIn(shown ^ 8'h5a, 7000);
        frame(16);
        dbSel <= 2'h3;
        setIn(shown ^ 8'ha5, 7000);
        frame(16);
        conclude;
    end
endmodule // oidsr_top_test
